// ===== common/fpu_issue_map.svh
// Selector codes, reset values, masks and cycle figures of the issue block.
`ifndef FPU_ISSUE_MAP_SVH
`define FPU_ISSUE_MAP_SVH
// ----------------------------------------------------------------
// System register selectors
// ----------------------------------------------------------------
`define SEL_SYSTEM_ID 4'h0
`define SEL_STATUS_CTRL 4'h1
`define SEL_FEATURE_1 4'h6
`define SEL_FEATURE_0 4'h7
`define SEL_EXC_ENABLE 4'h8
// ----------------------------------------------------------------
// Reset values, fixed values and write masks
// ----------------------------------------------------------------
`define RST_STATUS_CTRL 32'h00000000
`define RST_EXC_ENABLE 32'h00000000
`define VAL_FEATURE_1 32'h01000011
`define VAL_FEATURE_0 32'h10110221
`define STATUS_CTRL_WMASK 32'hf7f7009f
`define EXC_ENABLE_WMASK 32'h40000000
`define EXC_EN_BIT 30
// ----------------------------------------------------------------
// Coprocessor access field codes
// ----------------------------------------------------------------
`define CP_PRIV 2'h1
`define CP_FULL 2'h3
// ----------------------------------------------------------------
// Throughput, forward and writeback cycles
// ----------------------------------------------------------------
`define THR_ADD 3'h1
`define FWD_ADD 3'h4
`define WB_ADD 3'h4
`define THR_MUL_S 3'h1
`define FWD_MUL_S 3'h5
`define WB_MUL_S 3'h5
`define THR_MUL_D 3'h2
`define FWD_MUL_D 3'h6
`define WB_MUL_D 3'h6
`define THR_MOVE 3'h1
`define FWD_MOVE 3'h1
`define WB_MOVE 3'h2
`define THR_HOST 3'h1
`define WB_HOST 3'h3
`endif

// ===== common/fpu_issue_pkg.sv
// Types shared by the issue control block and its system register bank.
package fpu_issue_pkg;
`include "fpu_issue_map.svh"

  typedef logic [2:0] lat_t;

  typedef enum logic [2:0] {
    OP_ADD_CVT = 3'b000,
    OP_MUL = 3'b001,
    OP_MOVE = 3'b010,
    OP_TO_UNIT = 3'b011,
    OP_TO_HOST = 3'b100
  } op_class_e;

  typedef struct packed {
    lat_t thr;
    lat_t fwd;
    lat_t wb;
  } timing_s;

endpackage : fpu_issue_pkg

// ===== hw/fpu_issue_ctrl.sv
// Issue interlock, result timing and access gating of the floating-point unit.
// How it works
// - throughput gaps block the next issue
// - latency counts cycles until result is usable
// - forward for read-after-write, writeback for write-after-write
// - stalls freeze all counters and issue
// - add, subtract, convert: one, four, four
// - multiply one/five single, two/six double
// - moves and transfers in: one, one, two
// - transfers to host: no forward, three writeback
// - every system register is 32 bits
// - unassigned registers read zero, ignore writes
// - reset clears status and enable, fixed features
// - id, features, enable need privileged mode
// - status register needs global enable set
// - host access registers also gate access
`timescale 1ns/1ns
`include "fpu_issue_map.svh"
module fpu_issue_ctrl import fpu_issue_pkg::*; #(
  parameter int NREGS = 32,
  parameter logic [31:0] ID_VALUE = 32'h5a000001 // Arbitrary value.
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Instruction issue
  input wire logic issue_valid_in,
  input wire op_class_e op_class_in,
  input wire logic double_in,
  input wire logic [$clog2(NREGS)-1:0] dest_in,
  input wire logic [$clog2(NREGS)-1:0] src_a_in,
  input wire logic [$clog2(NREGS)-1:0] src_b_in,
  input wire logic [1:0] use_src_in,
  // Pipeline stalls
  input wire logic fpu_stall_in,
  input wire logic host_stall_in,
  // Host mode and access control
  input wire logic privileged_in,
  input wire logic nonsecure_in,
  input wire logic [3:0] coprocessor_access_register_in,
  input wire logic [1:0] nonsecure_access_register_in,
  // System register transfer
  input wire logic sysreg_valid_in,
  input wire logic sysreg_write_in,
  input wire logic [3:0] sysreg_sel_in,
  input wire logic [31:0] sysreg_wdata_in,
  // Issue answer
  output logic issue_accept_out,
  output logic issue_retry_out,
  output logic issue_undef_out,
  output logic host_data_ready_out,
  // System register answer
  output logic [31:0] sysreg_rdata_out,
  output logic sysreg_done_out,
  output logic sysreg_refused_out,
  // Unit state
  output logic fp_enable_out,
  output logic [5:0] status_flags_out
);
  localparam int AW = $clog2(NREGS);

  // ----------------------------------------------------------------
  // Per-class timing
  // ----------------------------------------------------------------
  function automatic timing_s class_timing(input op_class_e cls,
                                           input logic dbl);
    timing_s t;
    t = '{thr: `THR_MOVE, fwd: `FWD_MOVE, wb: `WB_MOVE};
    case (cls)
      OP_ADD_CVT: t = '{thr: `THR_ADD, fwd: `FWD_ADD, wb: `WB_ADD};
      OP_MUL: begin
        if (dbl)
          t = '{thr: `THR_MUL_D, fwd: `FWD_MUL_D, wb: `WB_MUL_D};
        else
          t = '{thr: `THR_MUL_S, fwd: `FWD_MUL_S, wb: `WB_MUL_S};
      end
      OP_MOVE: t = '{thr: `THR_MOVE, fwd: `FWD_MOVE, wb: `WB_MOVE};
      OP_TO_UNIT: t = '{thr: `THR_MOVE, fwd: `FWD_MOVE, wb: `WB_MOVE};
      OP_TO_HOST: t = '{thr: `THR_HOST, fwd: 3'h0, wb: `WB_HOST};
      default: t = '{thr: `THR_MOVE, fwd: `FWD_MOVE, wb: `WB_MOVE};
    endcase
    return t;
  endfunction : class_timing

  // A coprocessor number is usable when its access field grants the
  // current mode and, in the non-secure state, its non-secure bit is set.
  function automatic logic cp_grant(input logic [1:0] fld,
                                    input logic ns_bit,
                                    input logic priv,
                                    input logic ns);
    return (!ns || ns_bit) && (fld == `CP_FULL || (fld == `CP_PRIV && priv));
  endfunction : cp_grant

  // ----------------------------------------------------------------
  // Decision logic
  // ----------------------------------------------------------------
  timing_s tm;
  logic stall_any;
  logic cp_ok_a;
  logic cp_ok_b;
  logic cp_ok_op;
  logic perm_ok;
  logic writes_dest;
  logic raw_hit;
  logic waw_hit;
  logic thr_busy;
  logic take;
  logic [2:0] thr_cnt_r;
  logic [2:0] fwd_cnt_r [NREGS];
  logic [2:0] wb_cnt_r [NREGS];
  logic [2:0] host_pipe_r;
  op_class_e acc_class_r;
  logic acc_dbl_r;
  logic [AW-1:0] acc_dest_r;

  assign tm = class_timing(op_class_in, double_in);
  assign stall_any = fpu_stall_in || host_stall_in;
  assign cp_ok_a = cp_grant(coprocessor_access_register_in[1:0],
                            nonsecure_access_register_in[0],
                            privileged_in, nonsecure_in);
  assign cp_ok_b = cp_grant(coprocessor_access_register_in[3:2],
                            nonsecure_access_register_in[1],
                            privileged_in, nonsecure_in);
  // Double-precision work goes through the second coprocessor number.
  assign cp_ok_op = double_in ? cp_ok_b : cp_ok_a;
  assign perm_ok = fp_enable_out && cp_ok_op;
  assign writes_dest = op_class_in != OP_TO_HOST;

  // A source is blocked while the producer's forward count is running.
  assign raw_hit = (use_src_in[0] && fwd_cnt_r[src_a_in] != 3'h0) ||
                   (use_src_in[1] && fwd_cnt_r[src_b_in] != 3'h0);

  // A new writer must land strictly after any pending write to the same
  // register, otherwise the older result would overwrite the newer one.
  assign waw_hit = writes_dest && wb_cnt_r[dest_in] != 3'h0 &&
                   wb_cnt_r[dest_in] >= tm.wb - 3'h1;

  assign thr_busy = thr_cnt_r != 3'h0;

  assign take = issue_valid_in && perm_ok && !stall_any && !thr_busy &&
                !raw_hit && !waw_hit;

  // ----------------------------------------------------------------
  // Issue answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      issue_accept_out <= 1'b0;
      issue_retry_out <= 1'b0;
      issue_undef_out <= 1'b0;
    end else begin
      issue_accept_out <= take;
      issue_retry_out <= issue_valid_in && perm_ok && !take;
      issue_undef_out <= issue_valid_in && !perm_ok;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_class_r <= OP_ADD_CVT;
      acc_dbl_r <= 1'b0;
      acc_dest_r <= '0;
    end else if (take) begin
      acc_class_r <= op_class_in;
      acc_dbl_r <= double_in;
      acc_dest_r <= dest_in;
    end
  end

  // ----------------------------------------------------------------
  // Throughput gap
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in)
      thr_cnt_r <= 3'h0;
    else if (take)
      thr_cnt_r <= tm.thr - 3'h1;
    else if (!stall_any && thr_busy)
      thr_cnt_r <= thr_cnt_r - 3'h1;
  end

  // ----------------------------------------------------------------
  // Result scoreboard
  // ----------------------------------------------------------------
  // Counts are loaded one short so that a latency of one lets the
  // dependent instruction issue on the very next cycle.
  for (genvar i = 0; i < NREGS; i++) begin : g_sb
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        fwd_cnt_r[i] <= 3'h0;
        wb_cnt_r[i] <= 3'h0;
      end else if (take && writes_dest && dest_in == AW'(i)) begin
        fwd_cnt_r[i] <= tm.fwd - 3'h1;
        wb_cnt_r[i] <= tm.wb - 3'h1;
      end else if (!stall_any) begin
        if (fwd_cnt_r[i] != 3'h0)
          fwd_cnt_r[i] <= fwd_cnt_r[i] - 3'h1;
        if (wb_cnt_r[i] != 3'h0)
          wb_cnt_r[i] <= wb_cnt_r[i] - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfers to the host
  // ----------------------------------------------------------------
  // No forwarding exists for these; the host sees its data ready three
  // unstalled cycles after the issue edge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_pipe_r <= 3'h0;
      host_data_ready_out <= 1'b0;
    end else if (stall_any) begin
      host_data_ready_out <= 1'b0;
    end else begin
      host_pipe_r <= {host_pipe_r[1:0], take && !writes_dest};
      host_data_ready_out <= host_pipe_r[2];
    end
  end

  // ----------------------------------------------------------------
  // System registers
  // ----------------------------------------------------------------
  // Register accesses use the first coprocessor number; software brings
  // the unit up by opening the access registers before setting enable.
  logic [31:0] status_r;
  logic [31:0] exc_r;

  fpu_sysreg_bank #(
    .ID_VALUE(ID_VALUE)
  ) u_bank (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .acc_valid_in(sysreg_valid_in),
    .acc_write_in(sysreg_write_in),
    .acc_sel_in(sysreg_sel_in),
    .acc_wdata_in(sysreg_wdata_in),
    .privileged_in(privileged_in),
    .cp_ok_in(cp_ok_a),
    .rdata_out(sysreg_rdata_out),
    .done_out(sysreg_done_out),
    .refused_out(sysreg_refused_out),
    .status_out(status_r),
    .exc_out(exc_r)
  );

  assign fp_enable_out = exc_r[`EXC_EN_BIT];
  assign status_flags_out = {status_r[7], status_r[4:0]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_dmul_gap;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_MUL && acc_dbl_r |=> !issue_accept_out;
  endproperty
  a_dmul_gap: assert property (p_dmul_gap) else $error("double multiply gap broken");

  property p_add_lat;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_ADD_CVT
      |-> fwd_cnt_r[acc_dest_r] == 3'h3 && wb_cnt_r[acc_dest_r] == 3'h3;
  endproperty
  a_add_lat: assert property (p_add_lat) else $error("add latency wrong");

  property p_smul_lat;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_MUL && !acc_dbl_r
      |-> fwd_cnt_r[acc_dest_r] == 3'h4;
  endproperty
  a_smul_lat: assert property (p_smul_lat) else $error("multiply latency wrong");

  property p_move_lat;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_MOVE
      |-> fwd_cnt_r[acc_dest_r] == 3'h0 && wb_cnt_r[acc_dest_r] == 3'h1;
  endproperty
  a_move_lat: assert property (p_move_lat) else $error("move latency wrong");

  property p_raw_block;
    @(posedge clk_in) disable iff (rst_in)
    issue_valid_in && use_src_in[0] && fwd_cnt_r[src_a_in] != 3'h0
      |=> !issue_accept_out;
  endproperty
  a_raw_block: assert property (p_raw_block) else $error("dependent issue not held");

  property p_stall_freeze;
    @(posedge clk_in) disable iff (rst_in)
    stall_any |=> !issue_accept_out && $stable(thr_cnt_r) && $stable(host_pipe_r);
  endproperty
  a_stall_freeze: assert property (p_stall_freeze) else $error("stall did not freeze");

  property p_host_ready;
    @(posedge clk_in) disable iff (rst_in)
    (issue_accept_out && acc_class_r == OP_TO_HOST && !stall_any) ##1 (!stall_any) [*2]
      |=> host_data_ready_out;
  endproperty
  a_host_ready: assert property (p_host_ready) else $error("host data late");

  property p_disabled_undef;
    @(posedge clk_in) disable iff (rst_in)
    issue_valid_in && !fp_enable_out |=> issue_undef_out && !issue_accept_out;
  endproperty
  a_disabled_undef: assert property (p_disabled_undef) else $error("disabled issue taken");

  property p_cp_gate;
    @(posedge clk_in) disable iff (rst_in)
    sysreg_valid_in && coprocessor_access_register_in == 4'h0 |=> sysreg_refused_out;
  endproperty
  a_cp_gate: assert property (p_cp_gate) else $error("access without grant");

  property p_thr_gap;
    @(posedge clk_in) disable iff (rst_in)
    issue_valid_in && thr_busy |=> !issue_accept_out;
  endproperty
  a_thr_gap: assert property (p_thr_gap) else $error("gap not held");

  property p_dmul_lat;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_MUL && acc_dbl_r |-> fwd_cnt_r[acc_dest_r] == 3'h5;
  endproperty
  a_dmul_lat: assert property (p_dmul_lat) else $error("double multiply latency wrong");

  property p_unit_lat;
    @(posedge clk_in) disable iff (rst_in)
    issue_accept_out && acc_class_r == OP_TO_UNIT |-> wb_cnt_r[acc_dest_r] == 3'h1;
  endproperty
  a_unit_lat: assert property (p_unit_lat) else $error("transfer in latency wrong");

  property p_one_answer;
    @(posedge clk_in) disable iff (rst_in)
    issue_valid_in |=> $onehot({issue_accept_out, issue_retry_out, issue_undef_out});
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("offer answer not unique");

  property p_grant_undef;
    @(posedge clk_in) disable iff (rst_in)
    issue_valid_in && !cp_ok_op |=> issue_undef_out;
  endproperty
  a_grant_undef: assert property (p_grant_undef) else $error("issue without grant");

endmodule : fpu_issue_ctrl

// ===== hw/fpu_sysreg_bank.sv
// System register bank with mode or enable gating of each mapped access.
`timescale 1ns/1ns
`include "fpu_issue_map.svh"
module fpu_sysreg_bank import fpu_issue_pkg::*; #(
  parameter logic [31:0] ID_VALUE = 32'h5a000001 // Arbitrary value.
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Access request
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [3:0] acc_sel_in,
  input wire logic [31:0] acc_wdata_in,
  input wire logic privileged_in,
  input wire logic cp_ok_in,
  // Answer and state
  output logic [31:0] rdata_out,
  output logic done_out,
  output logic refused_out,
  output logic [31:0] status_out,
  output logic [31:0] exc_out
);
  logic known;
  logic allow;
  logic ok;
  logic [31:0] value;

  always_comb begin
    known = 1'b1;
    allow = privileged_in;
    value = 32'h00000000;
    case (acc_sel_in)
      `SEL_SYSTEM_ID: value = ID_VALUE;
      `SEL_FEATURE_1: value = `VAL_FEATURE_1;
      `SEL_FEATURE_0: value = `VAL_FEATURE_0;
      `SEL_EXC_ENABLE: value = exc_out;
      `SEL_STATUS_CTRL: begin
        value = status_out;
        allow = exc_out[`EXC_EN_BIT];
      end
      default: begin
        known = 1'b0;
        allow = 1'b1;
      end
    endcase
    ok = cp_ok_in && allow;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      refused_out <= 1'b0;
      rdata_out <= 32'h00000000;
    end else begin
      done_out <= acc_valid_in && ok;
      refused_out <= acc_valid_in && !ok;
      rdata_out <= (acc_valid_in && ok && !acc_write_in && known) ? value : 32'h00000000;
    end
  end

  // Reserved bits are masked on write so they always read as zero.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_out <= `RST_STATUS_CTRL;
      exc_out <= `RST_EXC_ENABLE;
    end else if (acc_valid_in && acc_write_in && ok) begin
      if (acc_sel_in == `SEL_STATUS_CTRL)
        status_out <= acc_wdata_in & `STATUS_CTRL_WMASK;
      if (acc_sel_in == `SEL_EXC_ENABLE)
        exc_out <= acc_wdata_in & `EXC_ENABLE_WMASK;
    end
  end

  property p_unmapped;
    @(posedge clk_in) disable iff (rst_in)
    acc_valid_in && cp_ok_in && !known |=> done_out && rdata_out == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_status_gate;
    @(posedge clk_in) disable iff (rst_in)
    acc_valid_in && acc_sel_in == `SEL_STATUS_CTRL && !exc_out[`EXC_EN_BIT]
      |=> refused_out && $stable(status_out);
  endproperty
  a_status_gate: assert property (p_status_gate) else $error("status access not refused");

  property p_user_gate;
    @(posedge clk_in) disable iff (rst_in)
    acc_valid_in && !privileged_in && acc_sel_in == `SEL_EXC_ENABLE
      |=> refused_out && $stable(exc_out);
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user access not refused");

  property p_reset_vals;
    @(posedge clk_in) rst_in |=> status_out == `RST_STATUS_CTRL && exc_out == `RST_EXC_ENABLE;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

endmodule : fpu_sysreg_bank

// ===== verification/fpu_issue_timing_and_sysreg_access_tb.sv
// Self-checking testbench of the issue timing and system register block.
`timescale 1ns/1ns
`include "fpu_issue_map.svh"
module fpu_issue_timing_and_sysreg_access_tb import fpu_issue_pkg::*;;
  localparam logic [31:0] ID_VAL = 32'h5a000001; // Arbitrary value.
  localparam logic [2:0] ACC = 3'h4;
  localparam logic [2:0] RTY = 3'h2;
  localparam logic [2:0] UND = 3'h1;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic issue_valid_in = 1'b0;
  op_class_e op_class_in = OP_ADD_CVT;
  logic double_in = 1'b0;
  logic [1:0] dest_in = 2'h0;
  logic [1:0] src_a_in = 2'h0;
  logic [1:0] src_b_in = 2'h0;
  logic [1:0] use_src_in = 2'h0;
  logic fpu_stall_in = 1'b0;
  logic host_stall_in = 1'b0;
  logic sysreg_valid_in = 1'b0;
  logic sysreg_write_in = 1'b0;
  logic [3:0] sysreg_sel_in = 4'h0;
  logic [31:0] sysreg_wdata_in = 32'h0;
  logic privileged_in;
  logic nonsecure_in;
  logic [3:0] cpa;
  logic [1:0] nsa;
  logic acc_o;
  logic rty_o;
  logic und_o;
  logic hrdy_o;
  logic [31:0] rdata_o;
  logic done_o;
  logic ref_o;
  logic fp_enable_out;
  logic [5:0] status_flags_out;
  int n_errors = 0;
  int checked = 0;
  always #25 clk_in = ~clk_in;
  host_access_model host (
    .clk_in(clk_in),
    .privileged_out(privileged_in),
    .nonsecure_out(nonsecure_in),
    .coprocessor_access_register_out(cpa),
    .nonsecure_access_register_out(nsa)
  );
  fpu_issue_ctrl #(.NREGS(4), .ID_VALUE(ID_VAL)) dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .issue_valid_in(issue_valid_in), .op_class_in(op_class_in), .double_in(double_in),
    .dest_in(dest_in), .src_a_in(src_a_in), .src_b_in(src_b_in), .use_src_in(use_src_in),
    .fpu_stall_in(fpu_stall_in), .host_stall_in(host_stall_in),
    .privileged_in(privileged_in), .nonsecure_in(nonsecure_in),
    .coprocessor_access_register_in(cpa), .nonsecure_access_register_in(nsa),
    .sysreg_valid_in(sysreg_valid_in), .sysreg_write_in(sysreg_write_in),
    .sysreg_sel_in(sysreg_sel_in), .sysreg_wdata_in(sysreg_wdata_in),
    .issue_accept_out(acc_o), .issue_retry_out(rty_o), .issue_undef_out(und_o),
    .host_data_ready_out(hrdy_o), .sysreg_rdata_out(rdata_o), .sysreg_done_out(done_o),
    .sysreg_refused_out(ref_o), .fp_enable_out(fp_enable_out),
    .status_flags_out(status_flags_out)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Answer is {done, refused}; read data must be zero outside a done read.
  task automatic sys(input logic wr, input logic [3:0] sel, input logic [31:0] wd,
                     input logic [1:0] exp_dr, input logic [31:0] exp_rd);
    @(negedge clk_in);
    sysreg_valid_in = 1'b1;
    sysreg_write_in = wr;
    sysreg_sel_in = sel;
    sysreg_wdata_in = wd;
    @(posedge clk_in);
    #1;
    check({30'h0, done_o, ref_o}, {30'h0, exp_dr});
    check(rdata_o, exp_rd);
    @(negedge clk_in);
    sysreg_valid_in = 1'b0;
  endtask : sys
  // Valid stays up on return so that offers can follow back to back.
  task automatic offer(input op_class_e op, input logic dbl, input logic [1:0] d,
                       input logic [1:0] s, input logic [1:0] u, input logic [1:0] stl,
                       output logic [2:0] ans);
    @(negedge clk_in);
    issue_valid_in = 1'b1;
    op_class_in = op;
    double_in = dbl;
    dest_in = d;
    src_a_in = s;
    src_b_in = s;
    use_src_in = u;
    {fpu_stall_in, host_stall_in} = stl;
    @(posedge clk_in);
    #1;
    ans = {acc_o, rty_o, und_o};
  endtask : offer
  task automatic idle();
    @(negedge clk_in);
    issue_valid_in = 1'b0;
    {fpu_stall_in, host_stall_in} = 2'h0;
  endtask : idle
  task automatic try1(input op_class_e op, input logic dbl, input logic [1:0] d,
                      input logic [1:0] s, input logic [1:0] u, input logic [2:0] exp);
    logic [2:0] a;
    offer(op, dbl, d, s, u, 2'h0, a);
    check({29'h0, a}, {29'h0, exp});
  endtask : try1
  // A reader of the producer's register is offered every cycle until taken.
  task automatic raw_gap(input op_class_e op, input logic dbl, input int fwd,
                         input logic [1:0] u, input int nst);
    logic [2:0] a;
    int k;
    repeat (8) @(negedge clk_in);
    try1(op, dbl, 2'h1, 2'h0, 2'h0, ACC);
    k = 0;
    a = 3'h0;
    while (a != ACC && k < 12) begin
      k++;
      offer(OP_ADD_CVT, 1'b0, 2'h2, 2'h1, u, (k <= nst) ? {k[0], ~k[0]} : 2'h0, a);
    end
    check(32'(k), 32'(fwd + nst));
    idle();
  endtask : raw_gap
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sysreg();
    sys(1'b0, `SEL_EXC_ENABLE, 32'h0, 2'h1, 32'h0);
    host.grant_secure();
    sys(1'b0, `SEL_SYSTEM_ID, 32'h0, 2'h2, ID_VAL);
    sys(1'b0, `SEL_FEATURE_1, 32'h0, 2'h2, `VAL_FEATURE_1);
    sys(1'b1, `SEL_FEATURE_0, 32'h0, 2'h2, 32'h0);
    sys(1'b0, `SEL_FEATURE_0, 32'h0, 2'h2, `VAL_FEATURE_0);
    sys(1'b0, `SEL_EXC_ENABLE, 32'h0, 2'h2, `RST_EXC_ENABLE);
    sys(1'b0, `SEL_STATUS_CTRL, 32'h0, 2'h1, 32'h0);
    sys(1'b1, 4'h3, 32'hffffffff, 2'h2, 32'h0);
    sys(1'b0, 4'h3, 32'h0, 2'h2, 32'h0);
    host.set_mode(1'b0, 1'b0);
    sys(1'b0, `SEL_SYSTEM_ID, 32'h0, 2'h1, 32'h0);
    sys(1'b1, `SEL_EXC_ENABLE, 32'h40000000, 2'h1, 32'h0);
    check({31'h0, fp_enable_out}, 32'h0);
    host.set_mode(1'b1, 1'b0);
    $display("test sysreg gating finished");
  endtask : t_sysreg
  task automatic t_enable();
    try1(OP_ADD_CVT, 1'b0, 2'h1, 2'h0, 2'h0, UND);
    idle();
    sys(1'b1, `SEL_EXC_ENABLE, 32'hffffffff, 2'h2, 32'h0);
    check({31'h0, fp_enable_out}, 32'h1);
    sys(1'b0, `SEL_EXC_ENABLE, 32'h0, 2'h2, `EXC_ENABLE_WMASK);
    host.set_mode(1'b0, 1'b0);
    sys(1'b0, `SEL_STATUS_CTRL, 32'h0, 2'h2, `RST_STATUS_CTRL);
    sys(1'b1, `SEL_STATUS_CTRL, 32'hffffffff, 2'h2, 32'h0);
    sys(1'b0, `SEL_STATUS_CTRL, 32'h0, 2'h2, `STATUS_CTRL_WMASK);
    check({26'h0, status_flags_out}, 32'h3f);
    host.set_mode(1'b1, 1'b0);
    $display("test enable sequence finished");
  endtask : t_enable
  task automatic t_grant();
    host.revoke();
    try1(OP_MOVE, 1'b0, 2'h0, 2'h0, 2'h0, UND);
    idle();
    host.set_mode(1'b1, 1'b1);
    host.grant_secure();
    try1(OP_MOVE, 1'b0, 2'h0, 2'h0, 2'h0, UND);
    idle();
    host.grant_both();
    try1(OP_MOVE, 1'b1, 2'h0, 2'h0, 2'h0, ACC);
    idle();
    host.set_mode(1'b1, 1'b0);
    $display("test access grant finished");
  endtask : t_grant
  task automatic t_timing();
    raw_gap(OP_ADD_CVT, 1'b0, 4, 2'h1, 0);
    raw_gap(OP_ADD_CVT, 1'b1, 4, 2'h2, 0);
    raw_gap(OP_MUL, 1'b0, 5, 2'h2, 0);
    raw_gap(OP_MUL, 1'b1, 6, 2'h1, 0);
    raw_gap(OP_MOVE, 1'b0, 1, 2'h1, 0);
    raw_gap(OP_TO_UNIT, 1'b1, 1, 2'h2, 0);
    raw_gap(OP_ADD_CVT, 1'b0, 4, 2'h1, 2);
    try1(OP_MUL, 1'b1, 2'h1, 2'h0, 2'h0, ACC);
    try1(OP_ADD_CVT, 1'b0, 2'h2, 2'h0, 2'h0, RTY);
    try1(OP_ADD_CVT, 1'b0, 2'h2, 2'h0, 2'h0, ACC);
    try1(OP_MOVE, 1'b0, 2'h3, 2'h0, 2'h0, ACC);
    try1(OP_ADD_CVT, 1'b0, 2'h3, 2'h0, 2'h0, ACC);
    try1(OP_MOVE, 1'b0, 2'h3, 2'h0, 2'h0, RTY);
    idle();
    $display("test issue timing finished");
  endtask : t_timing
  task automatic t_host();
    repeat (8) @(negedge clk_in);
    try1(OP_TO_HOST, 1'b0, 2'h0, 2'h0, 2'h0, ACC);
    try1(OP_TO_HOST, 1'b0, 2'h0, 2'h0, 2'h0, ACC);
    check({31'h0, hrdy_o}, 32'h0);
    idle();
    @(posedge clk_in);
    #1;
    check({31'h0, hrdy_o}, 32'h0);
    @(posedge clk_in);
    #1;
    check({31'h0, hrdy_o}, 32'h1);
    @(posedge clk_in);
    #1;
    check({31'h0, hrdy_o}, 32'h1);
    @(posedge clk_in);
    #1;
    check({31'h0, hrdy_o}, 32'h0);
    sys(1'b1, `SEL_EXC_ENABLE, 32'h0, 2'h2, 32'h0);
    sys(1'b0, `SEL_STATUS_CTRL, 32'h0, 2'h1, 32'h0);
    try1(OP_ADD_CVT, 1'b0, 2'h1, 2'h0, 2'h0, UND);
    idle();
    $display("test host transfer and disable finished");
  endtask : t_host
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    t_sysreg();
    t_enable();
    t_grant();
    t_timing();
    t_host();
    report_and_stop();
  end
  // The whole run needs under two hundred cycles; this limit only catches a hang.
  initial begin
    repeat (4000) @(posedge clk_in);
    n_errors++;
    $display("Watchdog expired at %0t ns", $time);
    report_and_stop();
  end
endmodule : fpu_issue_timing_and_sysreg_access_tb

// ===== verification/host_access_model.sv
// Host core model: processor mode, security state and the two access-control registers.
`timescale 1ns/1ns
`include "fpu_issue_map.svh"
module host_access_model (
  // Clock
  input wire logic clk_in,
  // Mode and access control towards the unit
  output logic privileged_out,
  output logic nonsecure_out,
  output logic [3:0] coprocessor_access_register_out,
  output logic [1:0] nonsecure_access_register_out
);
  initial begin
    privileged_out = 1'b1;
    nonsecure_out = 1'b0;
    coprocessor_access_register_out = 4'h0;
    nonsecure_access_register_out = 2'h0;
  end
  // Changes land at a falling edge so the unit always samples settled levels.
  task automatic set_mode(input logic priv, input logic ns);
    @(negedge clk_in);
    privileged_out = priv;
    nonsecure_out = ns;
  endtask : set_mode
  task automatic revoke();
    @(negedge clk_in);
    coprocessor_access_register_out = 4'h0;
    nonsecure_access_register_out = 2'h0;
  endtask : revoke
  task automatic grant_secure();
    @(negedge clk_in);
    coprocessor_access_register_out = {`CP_FULL, `CP_FULL};
  endtask : grant_secure
  // The non-secure bits must be in place before the access field opens.
  task automatic grant_both();
    @(negedge clk_in);
    nonsecure_access_register_out = 2'h3;
    @(negedge clk_in);
    coprocessor_access_register_out = {`CP_FULL, `CP_FULL};
  endtask : grant_both
endmodule : host_access_model
